// File: design/ibk_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef IBK_MAP_SVH
`define IBK_MAP_SVH
`define IBK_CFG_COUNT      12
`define IBK_OFS_LAST_CFG   8'h0B
`define IBK_OFS_NVM_CHECKSUM_FIRST     8'h0C
`define IBK_OFS_NVM_CHECKSUM_SECOND     8'h0D
`define IBK_OFS_FAULT      8'h0E
`define IBK_OFS_NVM_PROGRAM_STATUS    8'h0F
`define IBK_UNMAPPED       8'hFF
`define IBK_ADDR_BASE      4'h9
`define IBK_ADDR_LO_GND    3'h0
`define IBK_ADDR_LO_FLOAT  3'h2
`define IBK_ADDR_LO_VCC    3'h5
`define IBK_SEL_GND        2'h0
`define IBK_SEL_FLOAT      2'h1
`define IBK_SEL_VCC        2'h2
`define IBK_CMD_MSB        7
`define IBK_CMD_LSB        3
`define IBK_DONE_BIT       2
`define IBK_CRC_BIT        1
`define IBK_OPEN_BIT       0
`define IBK_CMD_PROGRAM    5'h12
`define IBK_CMD_IDLE       5'h00
`define IBK_DFLT_00        8'hC2
`define IBK_DFLT_01        8'h4B
`define IBK_DFLT_02        8'h02
`define IBK_DFLT_OTHER     8'h00
`define IBK_PROG_MS        50
`define IBK_CLK_KHZ        100000
`define IBK_PROG_CYCLES    (`IBK_PROG_MS * `IBK_CLK_KHZ)
`endif

// File: design/ibk_nvm.sv
// Nonvolatile default store: recall after reset, timed program cycle
`timescale 1ns/1ns
`include "ibk_map.svh"
module ibk_nvm #(
  parameter int unsigned PROG_CYCLES = `IBK_PROG_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire logic                          prog_start,
  input  wire logic [`IBK_CFG_COUNT*8-1:0]   cfg_flat,
  output logic                               recall_we,
  output logic [3:0]                         recall_idx,
  output ibk_pkg::ibk_byte_t                 recall_data,
  output logic                               recall_busy,
  output logic                               prog_busy,
  output logic                               prog_done,
  output ibk_pkg::ibk_byte_t                 cksum_sum,
  output ibk_pkg::ibk_byte_t                 cksum_xor
);
  logic [`IBK_CFG_COUNT*8-1:0] store_flat;
  logic [22:0]                 timer_r;
  logic [3:0]                  idx_r;
  ibk_pkg::ibk_byte_t          sum_nxt;
  ibk_pkg::ibk_byte_t          xor_nxt;

  function automatic ibk_pkg::ibk_byte_t dflt(input int i);
    case (i)
      0:       dflt = `IBK_DFLT_00;
      1:       dflt = `IBK_DFLT_01;
      2:       dflt = `IBK_DFLT_02;
      default: dflt = `IBK_DFLT_OTHER;
    endcase
  endfunction

  // Entries take no reset: contents must outlive every reset
  genvar g;
  for (g = 0; g < `IBK_CFG_COUNT; g++) begin : gen_ent
    ibk_pkg::ibk_byte_t byte_r = dflt(g);
    always_ff @(posedge clk) begin
      if (ce && prog_start && !prog_busy) begin
        byte_r <= cfg_flat[g*8 +: 8];
      end
    end
    assign store_flat[g*8 +: 8] = byte_r;
  end

  always_comb begin
    sum_nxt = 8'h00;
    xor_nxt = 8'h00;
    for (int i = 0; i < `IBK_CFG_COUNT; i++) begin
      sum_nxt = 8'(sum_nxt + store_flat[i*8 +: 8]);
      xor_nxt = xor_nxt ^ store_flat[i*8 +: 8];
    end
  end

  // Recall walks the store one entry per cycle after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recall_busy <= 1'b1;
      recall_we   <= 1'b0;
      recall_idx  <= 4'h0;
      recall_data <= 8'h00;
      idx_r       <= 4'h0;
    end else if (ce) begin
      recall_we <= recall_busy;
      // Index ends one past the last entry, so it is only read while busy
      if (recall_busy) begin
        recall_idx  <= idx_r;
        recall_data <= store_flat[idx_r*8 +: 8];
        idx_r       <= 4'(idx_r + 4'h1);
        if (idx_r == 4'(`IBK_CFG_COUNT - 1)) begin
          recall_busy <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_busy <= 1'b0;
      prog_done <= 1'b0;
      timer_r   <= 23'h000000;
    end else if (ce) begin
      prog_done <= 1'b0;
      if (prog_start && !prog_busy) begin
        prog_busy <= 1'b1;
        timer_r   <= 23'h000000;
      end else if (prog_busy) begin
        timer_r <= 23'(timer_r + 23'h000001);
        if (timer_r == 23'(PROG_CYCLES - 1)) begin
          prog_busy <= 1'b0;
          prog_done <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cksum_sum <= 8'h00;
      cksum_xor <= 8'h00;
    end else if (ce && (recall_we || prog_done)) begin
      cksum_sum <= sum_nxt;
      cksum_xor <= xor_nxt;
    end
  end
endmodule // ibk_nvm

// File: design/ibk_pkg.sv
// Types shared by the serial register bank
package ibk_pkg;
  typedef enum logic [3:0] {
    IBK_IDLE      = 4'h0,
    IBK_ADDR      = 4'h1,
    IBK_ADDR_ACK  = 4'h2,
    IBK_REG       = 4'h3,
    IBK_REG_ACK   = 4'h4,
    IBK_WDATA     = 4'h5,
    IBK_WDATA_ACK = 4'h6,
    IBK_RDATA     = 4'h7,
    IBK_RDATA_ACK = 4'h8
  } ibk_state_e;
  typedef logic [7:0] ibk_byte_t;
endpackage

// File: design/ibk_top.sv
// Two-wire serial slave with sixteen registers and nonvolatile defaults
`timescale 1ns/1ns
`include "ibk_map.svh"
module ibk_top #(
  parameter int unsigned PROG_CYCLES = `IBK_PROG_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe_n,
  input  wire logic [1:0]                   addr_sel,
  input  wire logic [7:0]                   fault_flags_in,
  input  wire logic                         string_open_flag_in,
  output logic [`IBK_CFG_COUNT*8-1:0]       cfg_regs,
  output logic                              nvm_busy
);
  logic                  rst_meta_r;
  logic                  rst_sync_r;
  logic                  scl_q_r;
  logic                  sda_q_r;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  bus_start;
  logic                  bus_stop;
  ibk_pkg::ibk_state_e   state_r;
  logic [3:0]            bitcnt_r;
  ibk_pkg::ibk_byte_t    shift_r;
  ibk_pkg::ibk_byte_t    tx_r;
  ibk_pkg::ibk_byte_t    ptr_r;
  logic                  rw_r;
  logic                  mack_r;
  logic [6:0]            dev_addr_r;
  logic                  byte_done;
  logic                  addr_hit;
  logic                  commit;
  logic                  stat_wr;
  logic                  prog_start;
  logic [4:0]            cmd_r;
  logic                  done_r;
  logic                  crc_ok_r;
  ibk_pkg::ibk_byte_t    rd_byte;
  ibk_pkg::ibk_byte_t    nvm_program_status;
  logic                  recall_we;
  logic [3:0]            recall_idx;
  ibk_pkg::ibk_byte_t    recall_data;
  logic                  recall_busy;
  logic                  prog_busy;
  logic                  prog_done;
  ibk_pkg::ibk_byte_t    cksum_sum;
  ibk_pkg::ibk_byte_t    cksum_xor;

  // Reset release passes two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else if (ce) begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ibk_nvm #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_nvm (
    .clk         (clk),
    .rst_n       (rst_sync_r),
    .ce          (ce),
    .prog_start  (prog_start),
    .cfg_flat    (cfg_regs),
    .recall_we   (recall_we),
    .recall_idx  (recall_idx),
    .recall_data (recall_data),
    .recall_busy (recall_busy),
    .prog_busy   (prog_busy),
    .prog_done   (prog_done),
    .cksum_sum   (cksum_sum),
    .cksum_xor   (cksum_xor)
  );

  // Strap taken while recall runs, so after release and never under reset
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      dev_addr_r <= {`IBK_ADDR_BASE, `IBK_ADDR_LO_GND};
    end else if (ce && recall_busy) begin
      unique case (addr_sel)
        `IBK_SEL_FLOAT: dev_addr_r <= {`IBK_ADDR_BASE, `IBK_ADDR_LO_FLOAT};
        `IBK_SEL_VCC:   dev_addr_r <= {`IBK_ADDR_BASE, `IBK_ADDR_LO_VCC};
        default:        dev_addr_r <= {`IBK_ADDR_BASE, `IBK_ADDR_LO_GND};
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (ce) begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  assign scl_rise  = ce && scl_in && !scl_q_r;
  assign scl_fall  = ce && !scl_in && scl_q_r;
  assign bus_start = ce && scl_in && scl_q_r && sda_q_r && !sda_in;
  assign bus_stop  = ce && scl_in && scl_q_r && !sda_q_r && sda_in;
  assign byte_done = (bitcnt_r == 4'h8);

  // Commit on the falling edge that closes the data acknowledge
  assign commit = scl_fall && !bus_start && !bus_stop &&
                  (state_r == ibk_pkg::IBK_WDATA_ACK);

  // Status writes are refused while a program cycle runs
  assign stat_wr = commit && ptr_r == `IBK_OFS_NVM_PROGRAM_STATUS && !prog_busy;

  // No acknowledge until recall has taken the strap address
  assign addr_hit = (shift_r[7:1] == dev_addr_r) && !recall_busy;

  always_comb begin
    nvm_program_status = 8'h00;
    nvm_program_status[`IBK_CMD_MSB:`IBK_CMD_LSB] = cmd_r;
    nvm_program_status[`IBK_DONE_BIT] = done_r;
    nvm_program_status[`IBK_CRC_BIT]  = crc_ok_r;
    nvm_program_status[`IBK_OPEN_BIT] = string_open_flag_in;
  end

  always_comb begin
    if (ptr_r <= `IBK_OFS_LAST_CFG) begin
      rd_byte = cfg_regs[ptr_r[3:0]*8 +: 8];
    end else begin
      unique case (ptr_r)
        `IBK_OFS_NVM_CHECKSUM_FIRST:  rd_byte = cksum_sum;
        `IBK_OFS_NVM_CHECKSUM_SECOND:  rd_byte = cksum_xor;
        `IBK_OFS_FAULT:   rd_byte = fault_flags_in;
        `IBK_OFS_NVM_PROGRAM_STATUS: rd_byte = nvm_program_status;
        default:          rd_byte = `IBK_UNMAPPED;
      endcase
    end
  end

  // Bus sequencer: start or stop overrides any state
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r  <= ibk_pkg::IBK_IDLE;
      bitcnt_r <= 4'h0;
      shift_r  <= 8'h00;
      tx_r     <= 8'h00;
      ptr_r    <= 8'h00;
      rw_r     <= 1'b0;
      mack_r   <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (bus_start) begin
      state_r  <= ibk_pkg::IBK_ADDR;
      bitcnt_r <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (bus_stop) begin
      state_r  <= ibk_pkg::IBK_IDLE;
      sda_oe_n <= 1'b1;
    end else if (ce) begin
      unique case (state_r)
        ibk_pkg::IBK_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        ibk_pkg::IBK_ADDR, ibk_pkg::IBK_REG, ibk_pkg::IBK_WDATA: begin
          if (scl_rise && !byte_done) begin
            shift_r  <= {shift_r[6:0], sda_in};
            bitcnt_r <= 4'(bitcnt_r + 4'h1);
          end else if (scl_fall && byte_done) begin
            bitcnt_r <= 4'h0;
            if (state_r == ibk_pkg::IBK_ADDR) begin
              // Base 1001 excludes general call and 10-bit prefixes
              if (addr_hit) begin
                rw_r     <= shift_r[0];
                sda_oe_n <= 1'b0;
                state_r  <= ibk_pkg::IBK_ADDR_ACK;
              end else begin
                state_r <= ibk_pkg::IBK_IDLE;
              end
            end else if (state_r == ibk_pkg::IBK_REG) begin
              ptr_r    <= shift_r;
              sda_oe_n <= 1'b0;
              state_r  <= ibk_pkg::IBK_REG_ACK;
            end else begin
              sda_oe_n <= 1'b0;
              state_r  <= ibk_pkg::IBK_WDATA_ACK;
            end
          end
        end
        ibk_pkg::IBK_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              // Repeated start with read bit answers from the pointer
              tx_r     <= {rd_byte[6:0], 1'b0};
              sda_oe_n <= rd_byte[7];
              ptr_r    <= 8'(ptr_r + 8'h01);
              bitcnt_r <= 4'h0;
              state_r  <= ibk_pkg::IBK_RDATA;
            end else begin
              sda_oe_n <= 1'b1;
              state_r  <= ibk_pkg::IBK_REG;
            end
          end
        end
        ibk_pkg::IBK_REG_ACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            state_r  <= ibk_pkg::IBK_WDATA;
          end
        end
        ibk_pkg::IBK_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            ptr_r    <= 8'(ptr_r + 8'h01);
            state_r  <= ibk_pkg::IBK_WDATA;
          end
        end
        ibk_pkg::IBK_RDATA: begin
          if (scl_rise && !byte_done) begin
            bitcnt_r <= 4'(bitcnt_r + 4'h1);
          end else if (scl_fall && byte_done) begin
            sda_oe_n <= 1'b1;
            mack_r   <= 1'b0;
            state_r  <= ibk_pkg::IBK_RDATA_ACK;
          end else if (scl_fall) begin
            sda_oe_n <= tx_r[7];
            tx_r     <= {tx_r[6:0], 1'b0};
          end
        end
        ibk_pkg::IBK_RDATA_ACK: begin
          if (scl_rise) begin
            if (sda_in) begin
              // No acknowledge from the master ends the read
              state_r <= ibk_pkg::IBK_IDLE;
            end else begin
              mack_r <= 1'b1;
            end
          end else if (scl_fall && mack_r) begin
            tx_r     <= {rd_byte[6:0], 1'b0};
            sda_oe_n <= rd_byte[7];
            ptr_r    <= 8'(ptr_r + 8'h01);
            bitcnt_r <= 4'h0;
            state_r  <= ibk_pkg::IBK_RDATA;
          end
        end
        default: begin
          state_r  <= ibk_pkg::IBK_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Line is only ever pulled low; release is the enable alone
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sda_out <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
    end
  end

  // Configuration bytes: recall has priority over any bus write
  genvar g;
  for (g = 0; g < `IBK_CFG_COUNT; g++) begin : gen_cfg
    logic load_hit;
    logic write_hit;
    assign load_hit  = ce && recall_we && recall_idx == 4'(g);
    assign write_hit = commit && ptr_r == 8'(g);
    always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
        cfg_regs[g*8 +: 8] <= 8'h00;
      end else if (load_hit) begin
        cfg_regs[g*8 +: 8] <= recall_data;
      end else if (write_hit) begin
        // Writes during a program cycle land here, not in the store
        cfg_regs[g*8 +: 8] <= shift_r;
      end
    end
  end

  // Only the exact command starts a cycle; the store covers 0x00..0x0B
  assign prog_start = stat_wr && !prog_done &&
                      shift_r[`IBK_CMD_MSB:`IBK_CMD_LSB] ==
                      `IBK_CMD_PROGRAM;

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cmd_r  <= `IBK_CMD_IDLE;
      done_r <= 1'b0;
    end else if (ce) begin
      // A finished cycle wins, so done is never lost to a new command
      if (prog_done) begin
        cmd_r  <= `IBK_CMD_IDLE;
        done_r <= 1'b1;
      end else if (prog_start) begin
        cmd_r  <= `IBK_CMD_PROGRAM;
        done_r <= 1'b0;
      end else if (stat_wr) begin
        // Any other pattern is held but starts nothing
        cmd_r <= shift_r[`IBK_CMD_MSB:`IBK_CMD_LSB];
      end
    end
  end

  // Set once the last recalled byte has landed; only reset clears it
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      crc_ok_r <= 1'b0;
    end else if (ce && recall_we &&
                 recall_idx == 4'(`IBK_CFG_COUNT - 1)) begin
      crc_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      nvm_busy <= 1'b1;
    end else if (ce) begin
      // Timer inside the store bounds the cycle length
      nvm_busy <= recall_busy || prog_busy || prog_start;
    end
  end
endmodule // ibk_top

// File: dv/ibk_bus_master.sv
// Behavioural two-wire bus master on the far side of the block
`timescale 1ns/1ns
module ibk_bus_master (
  input  wire logic clk,
  input  wire logic line,
  output logic      scl,
  output logic      sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hp();
    repeat (8) @(posedge clk);
  endtask
  // Data only moves while the bus clock is low
  task automatic bitx(input logic b, output logic s);
    sda <= b;
    hp();
    scl <= 1'b1;
    hp();
    s = line;
    scl <= 1'b0;
    hp();
  endtask
  task automatic start();
    sda <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda <= 1'b0;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda <= 1'b1;
    hp();
  endtask
  task automatic wbyte(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ok &= !s;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] rg, dat,
                    output logic ok);
    ok = 1'b1;
    start();
    wbyte({dev, 1'b0}, ok);
    wbyte(rg, ok);
    wbyte(dat, ok);
    stop();
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] rg,
                    output logic [7:0] d, output logic ok);
    logic s;
    ok = 1'b1;
    start();
    wbyte({dev, 1'b0}, ok);
    wbyte(rg, ok);
    start();
    wbyte({dev, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, s);
    stop();
  endtask
endmodule // ibk_bus_master

// File: dv/ibk_monitor.sv
// Port checker for the serial register bank
`timescale 1ns/1ns
`include "ibk_map.svh"
module ibk_monitor #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        scl_in,
  input wire logic                        sda_out,
  input wire logic                        sda_oe_n,
  input wire logic [`IBK_CFG_COUNT*8-1:0] cfg_regs,
  input wire logic                        nvm_busy
);
  logic        rec_r;
  int unsigned busy_cnt;
  // Recall owns the registers from every reset until busy first drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rec_r <= 1'b1;
    else if (!nvm_busy) rec_r <= 1'b0;
  end
  // Program busy run length; a delay range cannot span a whole cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_cnt <= 0;
    else if (nvm_busy && !rec_r) busy_cnt <= busy_cnt + 1;
    else busy_cnt <= 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_open_drain: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
  chk_ack_hold: assert property ($rose(sda_oe_n) |-> !$past(scl_in))
    else $error("data released while bus clock high");
  chk_ack_setup: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data pulled while bus clock high");
  chk_commit_low: assert property (
    $changed(cfg_regs) && !rec_r |-> !scl_in && !$past(scl_in))
    else $error("register changed outside the ack falling edge");
  chk_recall_quiet: assert property (rec_r |-> sda_oe_n)
    else $error("bus answered during recall");
  chk_recall_busy: assert property ($rose(rst_n) |-> nvm_busy)
    else $error("busy low right after reset");
  chk_recall_time: assert property (
    $rose(rst_n) |-> ##[1:30] !nvm_busy)
    else $error("recall did not finish");
  chk_prog_hold: assert property ($rose(nvm_busy) |-> nvm_busy[*8])
    else $error("program cycle ended too early");
  chk_prog_time: assert property (
    busy_cnt <= PROG_CYCLES + 1)
    else $error("program cycle too long");
  cover property ($fell(sda_oe_n));
  cover property ($changed(cfg_regs) && !rec_r);
  cover property ($fell(nvm_busy) && !rec_r);
endmodule // ibk_monitor

// File: dv/ibk_tb_top.sv
// Testbench for the serial register bank
`timescale 1ns/1ns
`include "ibk_map.svh"
module ibk_tb_top;
  localparam int unsigned PROG = 2000;
  logic                        clk, rst_n, scl, msda, ok, open_f;
  logic                        sda_out, sda_oe_n, nvm_busy;
  logic [1:0]                  addr_sel;
  logic [7:0]                  flt, d;
  logic [`IBK_CFG_COUNT*8-1:0] cfg_regs;
  int                          failures, comparisons;
  // Open-drain wire with pull-up
  wire logic line = msda & (sda_oe_n | sda_out);
  ibk_top #(.PROG_CYCLES(PROG)) dut_u (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .scl_in(scl), .sda_in(line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
    .fault_flags_in(flt), .string_open_flag_in(open_f),
    .cfg_regs(cfg_regs), .nvm_busy(nvm_busy));
  ibk_bus_master m_u (.clk(clk), .line(line), .scl(scl), .sda(msda));
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] sel);
    addr_sel <= sel;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    check("busy", {7'h0, nvm_busy}, 8'h00);
  endtask
  task automatic t_defaults();
    logic [7:0] e;
    for (int n = 0; n < `IBK_CFG_COUNT; n++) begin
      e = n == 0 ? `IBK_DFLT_00 : n == 1 ? `IBK_DFLT_01 :
          n == 2 ? `IBK_DFLT_02 : `IBK_DFLT_OTHER;
      check("default", cfg_regs[8*n +: 8], e);
    end
    // Sum and xor of the factory store bytes
    m_u.rd(7'h48, `IBK_OFS_NVM_CHECKSUM_FIRST, d, ok);
    check("sum", d, 8'h0F);
    m_u.rd(7'h48, `IBK_OFS_NVM_CHECKSUM_SECOND, d, ok);
    check("xor", d, 8'h8B);
  endtask
  task automatic t_write_read();
    m_u.wr(7'h48, 8'h05, 8'hA5, ok);
    check("write ack", {7'h0, ok}, 8'h01);
    check("reg 05", cfg_regs[47:40], 8'hA5);
    m_u.rd(7'h48, 8'h05, d, ok);
    check("read 05", d, 8'hA5);
    m_u.wr(7'h48, `IBK_OFS_FAULT, 8'h55, ok);
    m_u.rd(7'h48, `IBK_OFS_FAULT, d, ok);
    check("fault ro", d, flt);
    m_u.rd(7'h48, 8'h10, d, ok);
    check("unmapped", d, `IBK_UNMAPPED);
  endtask
  task automatic t_address();
    logic [6:0] own [4] = '{7'h48, 7'h4A, 7'h4D, 7'h48};
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      m_u.wr(own[s], 8'h04, 8'h11 << s, ok);
      check("own ack", {7'h0, ok}, 8'h01);
      check("reg 04", cfg_regs[39:32], 8'h11 << s);
      m_u.wr(7'h00, 8'h04, 8'hEE, ok);
      check("general call", {7'h0, ok}, 8'h00);
      m_u.wr(7'h78, 8'h04, 8'hEE, ok);
      check("ten bit", {7'h0, ok}, 8'h00);
      m_u.wr(own[(s + 1) % 3], 8'h04, 8'hEE, ok);
      check("other ack", {7'h0, ok}, 8'h00);
      check("reg kept", cfg_regs[39:32], 8'h11 << s);
    end
  endtask
  task automatic t_program();
    do_reset(2'h0);
    m_u.wr(7'h48, 8'h00, 8'h5A, ok);
    m_u.wr(7'h48, `IBK_OFS_NVM_PROGRAM_STATUS, 8'h90, ok);
    m_u.rd(7'h48, `IBK_OFS_NVM_PROGRAM_STATUS, d, ok);
    check("prog run", d, {`IBK_CMD_PROGRAM, 3'b011});
    for (int i = 0; i < PROG && nvm_busy; i++) @(posedge clk);
    check("prog end", {7'h0, nvm_busy}, 8'h00);
    m_u.rd(7'h48, `IBK_OFS_NVM_PROGRAM_STATUS, d, ok);
    check("prog done", d, {`IBK_CMD_IDLE, 3'b111});
    do_reset(2'h0);
    check("recalled 00", cfg_regs[7:0], 8'h5A);
    check("recalled 01", cfg_regs[15:8], `IBK_DFLT_01);
    m_u.rd(7'h48, `IBK_OFS_NVM_CHECKSUM_FIRST, d, ok);
    check("new sum", d, 8'hA7);
    m_u.wr(7'h48, `IBK_OFS_NVM_PROGRAM_STATUS, 8'h50, ok);
    check("no start", {7'h0, nvm_busy}, 8'h00);
    m_u.rd(7'h48, `IBK_OFS_NVM_PROGRAM_STATUS, d, ok);
    check("cmd kept", d, 8'h53);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Bus work is a few tens of thousands of cycles
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    addr_sel = 2'h0;
    flt = 8'h3C;
    open_f = 1'b1;
    failures = 0;
    comparisons = 0;
    do_reset(2'h0);
    t_defaults();
    t_write_read();
    t_address();
    t_program();
    give_verdict();
  end
endmodule // ibk_tb_top
bind ibk_top ibk_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_u (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .cfg_regs(cfg_regs), .nvm_busy(nvm_busy));
